// [design/ddcps_pkg.sv]
// package for the preset select and channel binding register bank
// assumes a 32-bit apb slave on pclk; offsets are register indices, byte address = 4 * index
package ddcps_pkg;
    localparam logic [11:0] ddcps_idx_mode = 12'h214;
    localparam logic [11:0] ddcps_idx_sel = 12'h215;
    localparam logic [11:0] ddcps_idx_bind = 12'h216;
    localparam logic [11:0] ddcps_idx_rdiv = 12'h217;
    localparam logic [11:0] ddcps_idx_ctrl = 12'h218;
    localparam logic [11:0] ddcps_idx_stat = 12'h21f;

    localparam int ddcps_sel_a_lsb = 0;
    localparam int ddcps_sel_b_lsb = 2;
    localparam int ddcps_bind_a_bit = 0;
    localparam int ddcps_bind_b_bit = 1;
    localparam int ddcps_ctrl_link_bit = 0;
    localparam int ddcps_ctrl_cal_bit = 1;
    localparam int ddcps_ctrl_single_bit = 2;
    localparam int ddcps_ctrl_pda_bit = 3;
    localparam int ddcps_ctrl_pdb_bit = 4;

    localparam logic [1:0] ddcps_mode_rst = 2'h0;
    localparam logic [3:0] ddcps_sel_rst = 4'h0;
    localparam logic [1:0] ddcps_bind_rst = 2'h2;
    localparam logic [15:0] ddcps_rdiv_rst = 16'h0000;
    localparam logic [4:0] ddcps_ctrl_rst = 5'h00;

    localparam logic [1:0] ddcps_mode_regs = 2'h0;
    localparam logic [1:0] ddcps_mode_pins_ab = 2'h1;
    localparam logic [1:0] ddcps_mode_pins_a = 2'h2;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] sel_a;
        logic [1:0] sel_b;
        logic [1:0] bind_src;
        logic [15:0] rdiv;
        logic link_en;
        logic cal_en;
        logic single;
        logic pd_a;
        logic pd_b;
    } ddcps_cfg_s;

    typedef struct packed {
        logic [1:0] preset_a;
        logic [1:0] preset_b;
        logic src_a_is_b;
        logic src_b_is_b;
        logic dig_a_pd;
        logic dig_b_pd;
        logic [15:0] rdiv;
        logic rdiv_on;
    } ddcps_act_s;
endpackage

// [design/ddcps_resolve.sv]
// combinational resolution of active presets, sources and power-down
// assumes cfg and synchronised pin values already in the pclk domain
`timescale 1ns/1ps
module ddcps_resolve (
    input wire ddcps_pkg::ddcps_cfg_s cfg,
    input wire logic [1:0] pins_a,
    input wire logic [1:0] pins_b,
    output ddcps_pkg::ddcps_act_s act
);
    function automatic logic [1:0] pick(input logic [1:0] mode, input logic [1:0] reg_v,
                                        input logic [1:0] pin_v);
        logic [1:0] r;
        r = reg_v;
        case (mode)
            ddcps_pkg::ddcps_mode_regs: r = reg_v;
            ddcps_pkg::ddcps_mode_pins_ab, ddcps_pkg::ddcps_mode_pins_a: r = pin_v;
            default: r = reg_v;
        endcase
        return r;
    endfunction

    logic [1:0] pin_for_b;
    always_comb begin
        pin_for_b = (cfg.mode == ddcps_pkg::ddcps_mode_pins_a) ? pins_a : pins_b;
        act.preset_a = pick(cfg.mode, cfg.sel_a, pins_a);
        // single channel: b follows the a choice
        act.preset_b = cfg.single ? act.preset_a : pick(cfg.mode, cfg.sel_b, pin_for_b);
        act.src_a_is_b = cfg.bind_src[ddcps_pkg::ddcps_bind_a_bit];
        act.src_b_is_b = cfg.bind_src[ddcps_pkg::ddcps_bind_b_bit];
        act.dig_a_pd = act.src_a_is_b ? cfg.pd_b : cfg.pd_a;
        act.dig_b_pd = act.src_b_is_b ? cfg.pd_b : cfg.pd_a;
        act.rdiv = cfg.rdiv;
        act.rdiv_on = (cfg.rdiv != 16'h0000);
    end
endmodule

// [design/ddcps_top.sv]
// apb register bank for oscillator preset select, channel binding and reference divisor
// assumes a standard apb master on pclk; preset pins are asynchronous and synchronised here
//
// The APB register port was decided locally.
`timescale 1ns/1ps
// Behaviour
// - preset source mode 0 uses register selectors, 1 and 2 use pins, 3 is reserved.
// - in mode 0 dual channel, bits 3:2 pick the preset for down-converter b.
// - in single channel operation the b selector is ignored and a is used.
// - in mode 0, bits 1:0 (reset 0) pick the preset for down-converter a.
// - preset index n makes frequency and phase word n the active pair.
// - in single channel operation the a selector gives the oscillator frequency.
// - binding bit 1 (reset 1) feeds digital channel b from converter a (0) or b (1).
// - binding bit 0 (reset 0) feeds digital channel a from converter a (0) or b (1).
// - a digital channel powers down when its bound converter is powered down; the serial link enable is not affected.
// - the 16-bit divisor resets to 0, and 0 disables it.
// - one divisor value serves all presets.
module ddcps_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] ddc_a_preset_pins,
    input wire logic [1:0] ddc_b_preset_pins,
    output logic [1:0] ddc_a_preset_pick,
    output logic [1:0] ddc_b_preset_pick,
    output logic digital_a_source_b,
    output logic digital_b_source_b,
    output logic digital_a_powerdown,
    output logic digital_b_powerdown,
    output logic [15:0] oscillator_ref_divisor,
    output logic oscillator_divisor_enable,
    output logic serial_link_enable,
    output logic calibration_enable
);
    typedef struct packed {
        ddcps_pkg::ddcps_cfg_s cfg;
        logic [1:0] pa_s1;
        logic [1:0] pa_s2;
        logic [1:0] pb_s1;
        logic [1:0] pb_s2;
        ddcps_pkg::ddcps_act_s act_q;
        logic [31:0] rdata;
        logic err;
    } ddcps_state_s;

    ddcps_state_s st;
    ddcps_state_s next_st;
    ddcps_pkg::ddcps_act_s act;

    function automatic logic [11:0] reg_index(input logic [13:0] a);
        return a[13:2];
    endfunction

    function automatic logic mapped(input logic [11:0] i);
        return i == ddcps_pkg::ddcps_idx_mode || i == ddcps_pkg::ddcps_idx_sel ||
               i == ddcps_pkg::ddcps_idx_bind || i == ddcps_pkg::ddcps_idx_rdiv ||
               i == ddcps_pkg::ddcps_idx_ctrl || i == ddcps_pkg::ddcps_idx_stat;
    endfunction

    ddcps_resolve u_resolve (
        .cfg(st.cfg),
        .pins_a(st.pa_s2),
        .pins_b(st.pb_s2),
        .act(act)
    );

    logic [11:0] idx;
    logic wr;
    logic rd;

    always_comb begin
        next_st = st;
        idx = reg_index(paddr);
        wr = psel && penable && pwrite;
        rd = psel && penable && !pwrite;
        next_st.pa_s1 = ddc_a_preset_pins;
        next_st.pa_s2 = st.pa_s1;
        next_st.pb_s1 = ddc_b_preset_pins;
        next_st.pb_s2 = st.pb_s1;
        next_st.act_q = act;
        // refusal is decided in the setup cycle so pslverr stands for the whole access phase
        if (psel && !penable) begin
            next_st.err = !mapped(idx);
        end
        if (wr && mapped(idx)) begin
            case (idx)
                ddcps_pkg::ddcps_idx_mode: begin
                    if (pstrb[0]) next_st.cfg.mode = pwdata[1:0];
                end
                ddcps_pkg::ddcps_idx_sel: begin
                    if (pstrb[0]) begin
                        next_st.cfg.sel_a = pwdata[ddcps_pkg::ddcps_sel_a_lsb +: 2];
                        next_st.cfg.sel_b = pwdata[ddcps_pkg::ddcps_sel_b_lsb +: 2];
                    end
                end
                ddcps_pkg::ddcps_idx_bind: begin
                    if (pstrb[0]) next_st.cfg.bind_src = pwdata[1:0];
                end
                ddcps_pkg::ddcps_idx_rdiv: begin
                    if (pstrb[0]) next_st.cfg.rdiv[7:0] = pwdata[7:0];
                    if (pstrb[1]) next_st.cfg.rdiv[15:8] = pwdata[15:8];
                end
                ddcps_pkg::ddcps_idx_ctrl: begin
                    if (pstrb[0]) begin
                        next_st.cfg.link_en = pwdata[ddcps_pkg::ddcps_ctrl_link_bit];
                        next_st.cfg.cal_en = pwdata[ddcps_pkg::ddcps_ctrl_cal_bit];
                        next_st.cfg.single = pwdata[ddcps_pkg::ddcps_ctrl_single_bit];
                        next_st.cfg.pd_a = pwdata[ddcps_pkg::ddcps_ctrl_pda_bit];
                        next_st.cfg.pd_b = pwdata[ddcps_pkg::ddcps_ctrl_pdb_bit];
                    end
                end
                default: begin
                end
            endcase
        end
        next_st.rdata = 32'h0;
        if (psel && !penable && !pwrite) begin
            case (idx)
                ddcps_pkg::ddcps_idx_mode: next_st.rdata = {30'h0, st.cfg.mode};
                ddcps_pkg::ddcps_idx_sel: next_st.rdata = {28'h0, st.cfg.sel_b, st.cfg.sel_a};
                ddcps_pkg::ddcps_idx_bind: next_st.rdata = {30'h0, st.cfg.bind_src};
                ddcps_pkg::ddcps_idx_rdiv: next_st.rdata = {16'h0, st.cfg.rdiv};
                ddcps_pkg::ddcps_idx_ctrl: next_st.rdata = {27'h0, st.cfg.pd_b, st.cfg.pd_a, st.cfg.single,
                                                            st.cfg.cal_en, st.cfg.link_en};
                ddcps_pkg::ddcps_idx_stat: next_st.rdata = {23'h0, act.rdiv_on, act.dig_b_pd, act.dig_a_pd,
                                                            act.src_b_is_b, act.src_a_is_b,
                                                            act.preset_b, act.preset_a};
                default: next_st.rdata = 32'h0;
            endcase
        end else if (rd) begin
            next_st.rdata = st.rdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.cfg.mode <= ddcps_pkg::ddcps_mode_rst;
            st.cfg.sel_a <= ddcps_pkg::ddcps_sel_rst[1:0];
            st.cfg.sel_b <= ddcps_pkg::ddcps_sel_rst[3:2];
            st.cfg.bind_src <= ddcps_pkg::ddcps_bind_rst;
            st.cfg.rdiv <= ddcps_pkg::ddcps_rdiv_rst;
            st.act_q.src_b_is_b <= ddcps_pkg::ddcps_bind_rst[ddcps_pkg::ddcps_bind_b_bit];
        end else begin
            st <= next_st;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && st.err;
    assign prdata = st.rdata;
    assign ddc_a_preset_pick = st.act_q.preset_a;
    assign ddc_b_preset_pick = st.act_q.preset_b;
    assign digital_a_source_b = st.act_q.src_a_is_b;
    assign digital_b_source_b = st.act_q.src_b_is_b;
    assign digital_a_powerdown = st.act_q.dig_a_pd;
    assign digital_b_powerdown = st.act_q.dig_b_pd;
    assign oscillator_ref_divisor = st.act_q.rdiv;
    assign oscillator_divisor_enable = st.act_q.rdiv_on;
    assign serial_link_enable = st.cfg.link_en;
    assign calibration_enable = st.cfg.cal_en;
endmodule

// [testbench/ddcps_chk.sv]
// checker for the preset select and binding register bank
// assumes the ports of ddcps_top on one pclk domain
`timescale 1ns/1ps
module ddcps_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic digital_a_source_b,
    input wire logic digital_b_source_b,
    input wire logic [15:0] oscillator_ref_divisor,
    input wire logic oscillator_divisor_enable,
    input wire logic serial_link_enable,
    input wire logic calibration_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [11:0] ix = paddr[13:2];
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite && pstrb[0];
    wire logic hit = ix inside {[12'h214:12'h218], 12'h21f};
    chk_ready_high: assert property (pready)
        else $error("pready low");
    chk_unmapped_err: assert property (acc && !hit |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    chk_mapped_ok: assert property (acc && hit |-> !pslverr)
        else $error("mapped access refused");
    chk_bind_src: assert property (wr && ix == ddcps_pkg::ddcps_idx_bind |-> ##2
        digital_a_source_b == $past(pwdata[0], 2) && digital_b_source_b == $past(pwdata[1], 2))
        else $error("binding output wrong");
    chk_div_write: assert property (wr && pstrb[1] && ix == ddcps_pkg::ddcps_idx_rdiv |-> ##2
        oscillator_ref_divisor == $past(pwdata[15:0], 2))
        else $error("divisor output wrong");
    chk_div_enable: assert property (oscillator_divisor_enable == (oscillator_ref_divisor != 16'h0))
        else $error("divisor enable wrong");
    chk_ctrl_en: assert property (wr && ix == ddcps_pkg::ddcps_idx_ctrl |-> ##2
        serial_link_enable == $past(pwdata[0], 2) && calibration_enable == $past(pwdata[1], 2))
        else $error("enable outputs wrong");
    chk_reset_vals: assert property ($rose(presetn) |-> digital_b_source_b && !digital_a_source_b)
        else $error("reset values wrong");
    cover property (wr && ix == ddcps_pkg::ddcps_idx_bind);
    cover property (acc && !hit);
    cover property (wr && ix == ddcps_pkg::ddcps_idx_rdiv);
endmodule
bind ddcps_top ddcps_chk chk_i (.*);

// [testbench/ddc_preset_select_channel_binding_tb_top.sv]
// self-checking bench for the preset select and binding register bank
// assumes ddcps_top with a zero-wait apb slave on pclk
`timescale 1ns/1ps
module ddc_preset_select_channel_binding_tb_top;
    localparam logic [11:0] mo = ddcps_pkg::ddcps_idx_mode;
    localparam logic [11:0] se = ddcps_pkg::ddcps_idx_sel;
    localparam logic [11:0] bi = ddcps_pkg::ddcps_idx_bind;
    localparam logic [11:0] rv = ddcps_pkg::ddcps_idx_rdiv;
    localparam logic [11:0] ct = ddcps_pkg::ddcps_idx_ctrl;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'h0;
    logic [1:0] ddc_a_preset_pins = 2'h0, ddc_b_preset_pins = 2'h0, ddc_a_preset_pick, ddc_b_preset_pick;
    logic digital_a_source_b, digital_b_source_b, digital_a_powerdown, digital_b_powerdown;
    logic [15:0] oscillator_ref_divisor;
    logic oscillator_divisor_enable, serial_link_enable, calibration_enable;
    int error_cnt = 0, num_checks = 0;
    ddcps_top uut (.*);
    always #25 pclk = ~pclk;
    task stop_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input logic [31:0] x, input logic [31:0] g);
        num_checks++;
        if (g !== x) begin
            error_cnt++;
            $display("unexpected %s exp %h got %h", n, x, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] i, input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q, output logic e);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'h1, 1'h0, w, i, 2'h0, d, s};
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 16);
        if (pready !== 1'h1) begin
            error_cnt++;
            stop_test();
        end else begin
            q = prdata;
            e = pslverr;
            {psel, penable} <= 2'h0;
        end
    endtask
    task automatic wr(input logic [11:0] i, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] q;
        logic e;
        apb(1'h1, i, d, s, q, e);
        chk("pslverr", 32'h0, {31'h0, e});
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic rd(input logic [11:0] i, input logic [31:0] x);
        logic [31:0] q;
        logic e;
        apb(1'h0, i, 32'h0, 4'h0, q, e);
        chk("prdata", x, q);
        chk("pslverr", {31'h0, i == 12'h219}, {31'h0, e});
    endtask
    task t_reset;
        rd(mo, 32'h0);
        rd(bi, 32'h2);
        rd(rv, 32'h0);
        chk("picks", 32'h0, {ddc_b_preset_pick, ddc_a_preset_pick});
        $display("test reset done");
    endtask
    task automatic t_modes;
        @(posedge pclk);
        {ddc_a_preset_pins, ddc_b_preset_pins} <= 4'h6;
        for (int i = 0; i < 4; i++) begin
            wr(se, 32'((3 - i) * 4 + i));
            chk("pick", 32'((3 - i) * 4 + i), {ddc_b_preset_pick, ddc_a_preset_pick});
        end
        for (int m = 0; m < 4; m++) begin
            wr(mo, 32'(m));
            chk("pick", m == 1 ? 32'h9 : m == 2 ? 32'h5 : 32'h3, {ddc_b_preset_pick, ddc_a_preset_pick});
        end
        wr(mo, 32'h0);
        wr(ct, 32'h4);
        wr(se, 32'h9);
        chk("single", 32'h5, {ddc_b_preset_pick, ddc_a_preset_pick});
        wr(ct, 32'h0);
        $display("test modes done");
    endtask
    task automatic t_bind;
        for (int b = 0; b < 4; b++) begin
            for (int p = 0; p < 4; p++) begin
                wr(ct, 32'h0);
                wr(bi, 32'(b));
                wr(ct, 32'(p * 8));
                chk("source", 32'(b), {digital_b_source_b, digital_a_source_b});
                chk("pd", {p[b[1]], p[b[0]]}, {digital_b_powerdown, digital_a_powerdown});
            end
        end
        wr(ct, 32'h3);
        chk("enables", 32'h3, {calibration_enable, serial_link_enable});
        wr(ct, 32'h0);
        wr(bi, 32'h2);
        $display("test bind done");
    endtask
    task automatic t_div;
        logic [31:0] q;
        logic e;
        wr(rv, 32'h2000);
        wr(rv, 32'h00ff, 4'h1);
        wr(se, 32'h5);
        chk("divisor", 32'h120ff, {oscillator_divisor_enable, oscillator_ref_divisor});
        rd(rv, 32'h20ff);
        rd(12'h21f, 32'h125);
        wr(rv, 32'h0);
        chk("divisor", 32'h0, {oscillator_divisor_enable, oscillator_ref_divisor});
        apb(1'h1, 12'h219, 32'hffffffff, 4'hf, q, e);
        chk("pslverr", 32'h1, {31'h0, e});
        rd(12'h219, 32'h0);
        $display("test divisor done");
    endtask
    task automatic t_rerst;
        wr(bi, 32'h1);
        wr(ct, 32'h3);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        #1;
        chk("source", 32'h2, {digital_b_source_b, digital_a_source_b});
        chk("enables", 32'h0, {calibration_enable, serial_link_enable});
        rd(bi, 32'h2);
        rd(ct, 32'h0);
        $display("test reset again done");
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_modes();
        t_bind();
        t_div();
        t_rerst();
        stop_test();
    end
endmodule
